/* File: rtl/ffsr_pkg.sv */
// Purpose: Constants and carrier types for the FET fault status and pump/relay register bank
// Assumes: 16-bit register port with separate write and read addresses
// Notes:   Each offset, field position, reset value is named once here
package ffsr_pkg;
   // ======================================================================
   // Register addresses
   // ======================================================================
   localparam logic [7:0]  FFSR_ADDR_FET_CLR_W   = 8'h0C;  // Fault clear, write only
   localparam logic [7:0]  FFSR_ADDR_FET_STAT_R  = 8'h8C;  // Fault status, read only
   localparam logic [7:0]  FFSR_ADDR_PUMP_CTRL_W = 8'h14;  // Pump/relay control, write
   localparam logic [7:0]  FFSR_ADDR_PUMP_CTRL_R = 8'h94;  // Pump/relay control, read back
   localparam logic [7:0]  FFSR_ADDR_STAT1_R     = 8'h88;  // First status word, read only

   // ======================================================================
   // Field positions
   // ======================================================================
   localparam int FFSR_BIT_ANSWER_CALC  = 2;   // Check-answer calculation error
   localparam int FFSR_BIT_ANSWER_TMO   = 1;   // Check-answer timeout
   localparam int FFSR_BIT_ANSWER_ACCUM = 0;   // Accumulated check-answer error
   localparam int FFSR_BIT_PUMP_ON      = 12;  // Charge pump enable
   localparam int FFSR_BIT_RELAY_THREE  = 8;   // Safety relay 3
   localparam int FFSR_BIT_RELAY_TWO    = 4;   // Safety relay 2
   localparam int FFSR_BIT_RELAY_ONE    = 0;   // Safety relay 1
   localparam int FFSR_FAULT_BITS       = 12;  // Used fault flags, bits 11..0

   // ======================================================================
   // Reset values
   // ======================================================================
   localparam logic [11:0] FFSR_RST_FET_STAT = 12'h000;  // All flags clear
   localparam logic        FFSR_RST_PUMP_ON  = 1'b1;     // Pump runs after reset
   localparam logic        FFSR_RST_RELAY    = 1'b0;     // Relays off after reset

   // ======================================================================
   // Carrier types
   // ======================================================================
   // Fault detector inputs, ordered so that bit index equals status bit
   typedef struct packed {
      logic gate_ovp_u_high;    // 11
      logic drain_fault_u_high; // 10
      logic gate_ovp_u_low;     // 9
      logic drain_fault_u_low;  // 8
      logic gate_ovp_v_high;    // 7
      logic drain_fault_v_high; // 6
      logic gate_ovp_v_low;     // 5
      logic drain_fault_v_low;  // 4
      logic gate_ovp_w_high;    // 3
      logic drain_fault_w_high; // 2
      logic gate_ovp_w_low;     // 1
      logic drain_fault_w_low;  // 0
   } ffsr_fault_t;

   // Register port request
   typedef struct packed {
      logic        wr_en;    // Write strobe, one cycle
      logic        rd_en;    // Read strobe, one cycle
      logic [7:0]  addr;     // Register address
      logic [15:0] wdata;    // Write data
   } ffsr_req_t;

   // Pump and relay drives
   typedef struct packed {
      logic pump_output_on;   // Charge pump on
      logic relay_three_on;   // Safety relay 3 on
      logic relay_two_on;     // Safety relay 2 on
      logic relay_one_on;     // Safety relay 1 on
   } ffsr_drive_t;

   // Whole module state
   typedef struct packed {
      logic [11:0] fault;     // Sticky fault flags
      ffsr_drive_t drive;     // Control register bits
      logic [15:0] rdata;     // Read data holding register
      logic        rvalid;    // Read answer strobe
   } ffsr_state_t;

   // Check-answer flag word
   typedef struct packed {
      logic answer_calc_fault;   // Calculation error
      logic answer_tmo_fault;    // Timeout
      logic answer_accum_fault;  // Accumulated error
   } ffsr_answer_t;
endpackage

/* File: rtl/ffsr_regs.sv */
// Purpose: FET fault status/clear and charge pump / relay control register bank
// Assumes: One clock, synchronous active-high reset, detector inputs on same clock
// Notes:   Serial framing lives elsewhere; this sees decoded register strobes
//
// Overview of operation
// - First status word (88h) bits 2,1,0 report check-answer errors
// - Phase U faults at bits 11 to 8
// - Phase V faults at bits 7 to 4
// - Phase W faults at bits 3 to 0
// - Fault flags read-only, reset to zero
// - Clear register bit N clears flag N
// - Writing zero to clear bit does nothing
// - Clear after recovery; diag output returns high
// - Clear ignored while fault still present
// - Control written at 14h, read at 94h
// - Bit 12 pump on, resets to one
// - Bit 8 relay three, resets zero
// - Bit 4 relay two, resets zero
// - Bit 0 relay one; others read zero
`timescale 1ns/1ns
module ffsr_regs (
   input  wire logic                  ref_clk_i,   // 50 MHz clock
   input  wire logic                  reset_i,     // Synchronous reset, high
   input  wire ffsr_pkg::ffsr_req_t   req_i,       // Register request
   input  wire ffsr_pkg::ffsr_fault_t fault_i,     // Detector levels
   input  wire ffsr_pkg::ffsr_answer_t answer_i,   // Check-answer flag levels
   output logic [15:0]                rdata_o,     // Read data, registered
   output logic                       rvalid_o,    // Read answer strobe
   output ffsr_pkg::ffsr_drive_t      drive_o,     // Pump and relay drives
   output logic                       diag_out_n_o // Low while any fault flag set
);
   import ffsr_pkg::*;

   // ======================================================================
   // State
   // ======================================================================
   ffsr_state_t state_ff;      // Registered state
   ffsr_state_t nxt_state;     // Next state
   logic [11:0] det;           // Detector vector, status bit order
   logic [11:0] clr_req;       // Clear request this cycle

   // Write hit check, used for both write addresses
   function automatic logic wr_hit(input ffsr_req_t r, input logic [7:0] a);
      return r.wr_en && (r.addr == a);
   endfunction

   assign det = fault_i;  // Packed order gives bits 11..0

   // ======================================================================
   // Next-state logic
   // ======================================================================
   always_comb begin
      nxt_state = state_ff;
      nxt_state.rvalid = 1'b0;
      // Clear strobes act on the write itself, nothing is stored
      clr_req = wr_hit(req_i, FFSR_ADDR_FET_CLR_W) ? req_i.wdata[11:0] : 12'h000;
      // Set wins; clear only where the detector is quiet
      nxt_state.fault = (state_ff.fault & ~(clr_req & ~det)) | det;
      // Control register write
      if (wr_hit(req_i, FFSR_ADDR_PUMP_CTRL_W)) begin
         nxt_state.drive.pump_output_on = req_i.wdata[FFSR_BIT_PUMP_ON];
         nxt_state.drive.relay_three_on = req_i.wdata[FFSR_BIT_RELAY_THREE];
         nxt_state.drive.relay_two_on   = req_i.wdata[FFSR_BIT_RELAY_TWO];
         nxt_state.drive.relay_one_on   = req_i.wdata[FFSR_BIT_RELAY_ONE];
      end
      // Read decode; unmapped addresses answer zero
      if (req_i.rd_en) begin
         nxt_state.rvalid = 1'b1;
         nxt_state.rdata  = 16'h0000;
         unique case (req_i.addr)
            FFSR_ADDR_FET_STAT_R: begin
               nxt_state.rdata[11:0] = state_ff.fault;
            end
            FFSR_ADDR_PUMP_CTRL_R: begin
               nxt_state.rdata[FFSR_BIT_PUMP_ON]     = state_ff.drive.pump_output_on;
               nxt_state.rdata[FFSR_BIT_RELAY_THREE] = state_ff.drive.relay_three_on;
               nxt_state.rdata[FFSR_BIT_RELAY_TWO]   = state_ff.drive.relay_two_on;
               nxt_state.rdata[FFSR_BIT_RELAY_ONE]   = state_ff.drive.relay_one_on;
            end
            FFSR_ADDR_STAT1_R: begin
               nxt_state.rdata[FFSR_BIT_ANSWER_CALC]  = answer_i.answer_calc_fault;
               nxt_state.rdata[FFSR_BIT_ANSWER_TMO]   = answer_i.answer_tmo_fault;
               nxt_state.rdata[FFSR_BIT_ANSWER_ACCUM] = answer_i.answer_accum_fault;
            end
            default: begin
               nxt_state.rdata = 16'h0000;
            end
         endcase
      end
   end

   // ======================================================================
   // State register
   // ======================================================================
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         state_ff.fault                <= FFSR_RST_FET_STAT;
         state_ff.drive.pump_output_on <= FFSR_RST_PUMP_ON;
         state_ff.drive.relay_three_on <= FFSR_RST_RELAY;
         state_ff.drive.relay_two_on   <= FFSR_RST_RELAY;
         state_ff.drive.relay_one_on   <= FFSR_RST_RELAY;
         state_ff.rdata                <= 16'h0000;
         state_ff.rvalid               <= 1'b0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ======================================================================
   // Outputs
   // ======================================================================
   assign rdata_o      = state_ff.rdata;
   assign rvalid_o     = state_ff.rvalid;
   assign drive_o      = state_ff.drive;
   assign diag_out_n_o = ~(|state_ff.fault);

   // ======================================================================
   // Assertions
   // ======================================================================
   // Clear register write with data bit b set
   sequence clr_write_s(int b);
      wr_hit(req_i, FFSR_ADDR_FET_CLR_W) && req_i.wdata[b];
   endsequence

   // Write to the pump and relay control register
   sequence ctrl_write_s;
      wr_hit(req_i, FFSR_ADDR_PUMP_CTRL_W);
   endsequence

   // Read strobe at one register address
   sequence read_at_s(logic [7:0] a);
      req_i.rd_en && req_i.addr == a;
   endsequence

   // Defaults seen at the first edge after any release of reset
   AST_RESET_VAL: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      $past(reset_i) |->
      drive_o == {FFSR_RST_PUMP_ON, FFSR_RST_RELAY, FFSR_RST_RELAY, FFSR_RST_RELAY} &&
      state_ff.fault == FFSR_RST_FET_STAT && !rvalid_o && diag_out_n_o)
      else $error("Reset values wrong");

   // A detector level always lands in its own flag, clear or not
   AST_SET_STICKY: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      (|det) |=> (state_ff.fault & $past(det)) == $past(det))
      else $error("Detected fault did not set flag");

   // Without a clear write the flags only gather new detections
   AST_HOLD_NO_CLR: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      !wr_hit(req_i, FFSR_ADDR_FET_CLR_W) |=>
      state_ff.fault == ($past(state_ff.fault) | $past(det)))
      else $error("Flag changed without clear");

   // Zero bits of a clear write leave their flags alone
   AST_KEEP: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      wr_hit(req_i, FFSR_ADDR_FET_CLR_W) |=>
      (state_ff.fault & $past(state_ff.fault) & ~$past(req_i.wdata[11:0])) ==
      ($past(state_ff.fault) & ~$past(req_i.wdata[11:0])))
      else $error("Flag lost under a zero clear bit");

   // A clear of a quiet flag takes it down at the next edge
   AST_CLR_OK: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      (clr_write_s(0) and !det[0]) |=> !state_ff.fault[0])
      else $error("Clear of quiet flag failed");

   // Same for the top flag, so both ends of the clear word are watched
   AST_CLR_TOP: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      (clr_write_s(11) and !det[11]) |=> !state_ff.fault[11])
      else $error("Clear of top flag failed");

   // A clear is refused while the detector still reports
   AST_CLR_BLOCKED: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      (clr_write_s(11) and det[11]) |=> state_ff.fault[11])
      else $error("Clear accepted during active fault");

   // Any detection pulls the diagnostic output low at the next edge
   AST_DIAG_LOW: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      (|det) |=> !diag_out_n_o)
      else $error("Diag output stayed high on a fault");

   // Clearing every set flag while all detectors are quiet releases the output
   AST_DIAG: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      (wr_hit(req_i, FFSR_ADDR_FET_CLR_W) && det == 12'h000 &&
       (state_ff.fault & ~req_i.wdata[11:0]) == 12'h000) |=> diag_out_n_o)
      else $error("Diag output not released after clear");

   // Pump bit follows its data bit on a control write
   AST_CTRL_WR: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      ctrl_write_s |=>
      drive_o.pump_output_on == $past(req_i.wdata[FFSR_BIT_PUMP_ON]))
      else $error("Pump bit not written");

   // Each relay bit follows its own data bit
   AST_RELAY_WR: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      ctrl_write_s |=>
      drive_o.relay_three_on == $past(req_i.wdata[FFSR_BIT_RELAY_THREE]) &&
      drive_o.relay_two_on == $past(req_i.wdata[FFSR_BIT_RELAY_TWO]) &&
      drive_o.relay_one_on == $past(req_i.wdata[FFSR_BIT_RELAY_ONE]))
      else $error("Relay bit not written");

   // Without a control write the drives stay where they are
   AST_CTRL_HOLD: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      !wr_hit(req_i, FFSR_ADDR_PUMP_CTRL_W) |=> $stable(drive_o))
      else $error("Drive changed without control write");

   // Read back shows the drives as they stood at the strobe, unused bits zero
   AST_CTRL_RD: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      read_at_s(FFSR_ADDR_PUMP_CTRL_R) |=> rvalid_o &&
      rdata_o == {3'h0, $past(drive_o.pump_output_on), 3'h0, $past(drive_o.relay_three_on),
                  3'h0, $past(drive_o.relay_two_on), 3'h0, $past(drive_o.relay_one_on)})
      else $error("Control read back wrong");

   // Upper status bits are unused and read zero
   AST_STAT_RD: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      read_at_s(FFSR_ADDR_FET_STAT_R) ##1 rvalid_o |->
      rdata_o[15:12] == 4'h0)
      else $error("Unused status bits not zero");

   // Status read returns the flags as they stood at the strobe
   AST_STAT_DATA: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      read_at_s(FFSR_ADDR_FET_STAT_R) |=> rdata_o[11:0] == $past(state_ff.fault))
      else $error("Status read data wrong");

   // Check-answer levels come back in bits 2 to 0, the rest reads zero
   AST_ANSWER_RD: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      read_at_s(FFSR_ADDR_STAT1_R) |=>
      rdata_o[2:0] == $past(answer_i) && rdata_o[15:3] == 13'h0000)
      else $error("Check-answer read wrong");

   // Read answer strobe stands exactly one cycle after each read strobe
   AST_RVALID_PULSE: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      rvalid_o == $past(req_i.rd_en))
      else $error("Read answer strobe misplaced");

   // Named detector fields land at their own status bits
   AST_MAP_U: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      fault_i.gate_ovp_u_high |=> state_ff.fault[11])
      else $error("Phase U field misplaced");

   AST_MAP_V: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      fault_i.drain_fault_v_low |=> state_ff.fault[4])
      else $error("Phase V field misplaced");

   AST_MAP_W: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      fault_i.drain_fault_w_low |=> state_ff.fault[0])
      else $error("Phase W field misplaced");
endmodule // ffsr_regs

/* File: verif/ffsr_host_model.sv */
// Purpose: Host model that issues register writes and reads to the bank
// Assumes: One-cycle strobes, read answer one cycle after the strobe
// Notes:   Requests start just after a rising edge and drop after the taking edge
`timescale 1ns/1ns
module ffsr_host_model (
   input  wire logic         ref_clk_i, // Shared clock
   input  wire logic         rvalid_i,  // Read answer strobe
   input  wire logic [15:0]  rdata_i,   // Read data
   output ffsr_pkg::ffsr_req_t req_o    // Request to the bank
);
   import ffsr_pkg::*;
   initial req_o = '0; // Idle port
   // =========================================================
   // Bus cycles
   // =========================================================
   // One write; a clear bit is written once and never written back
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge ref_clk_i);
      #1 req_o = '{1'b1, 1'b0, a, d};
      @(posedge ref_clk_i);
      #1 req_o = '0;
   endtask
   // One read; data counts only with its answer strobe
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge ref_clk_i);
      #1 req_o = '{1'b0, 1'b1, a, 16'h0000};
      @(posedge ref_clk_i);
      #1 req_o = '0;
      d = (rvalid_i === 1'b1) ? rdata_i : 16'hXXXX;
   endtask
endmodule // ffsr_host_model

/* File: verif/ffsr_regs_tb.sv */
// Purpose: Self-checking bench for the fault status and pump/relay bank
// Assumes: Host model drives the register port
// Notes:   Each scenario judges its own results
`timescale 1ns/1ns
module ffsr_regs_tb;
   import ffsr_pkg::*;
   logic          ref_clk_i = 1'b0;  // 50 MHz clock
   logic          reset_i   = 1'b1;  // Reset, high
   ffsr_fault_t   fault_i   = '0;    // Detector levels
   ffsr_answer_t  answer_i  = '0;    // Check-answer levels
   ffsr_req_t     req;               // Host request
   logic [15:0]   rdata;             // Read data
   logic          rvalid;            // Read answer strobe
   ffsr_drive_t   drive;             // Pump and relay drives
   logic          diag_n;            // Diagnostic, low active
   logic [15:0]   v;                 // Read result
   int            err_count    = 0;  // Mismatches
   int            total_checks = 0;  // Comparisons
   always #10 ref_clk_i = ~ref_clk_i; // Half period
   ffsr_regs ffsr_regs_inst (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .req_i(req),
      .fault_i(fault_i), .answer_i(answer_i), .rdata_o(rdata), .rvalid_o(rvalid),
      .drive_o(drive), .diag_out_n_o(diag_n));
   ffsr_host_model ffsr_host_model_inst (.ref_clk_i(ref_clk_i), .rvalid_i(rvalid),
      .rdata_i(rdata), .req_o(req));
   // =========================================================
   // Shared checking
   // =========================================================
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict;
      if (err_count == 0 && total_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // =========================================================
   // Scenarios
   // =========================================================
   // Values straight after reset
   task automatic t_reset;
      ffsr_host_model_inst.rd(8'h8C, v); check(v, 16'h0000);
      ffsr_host_model_inst.rd(8'h94, v); check(v, 16'h1000);
      check({12'h000, drive}, 16'h0008);
      check({15'h0, diag_n}, 16'h0001);
   endtask
   // Control patterns, wrong-address writes ignored
   task automatic t_ctrl;
      logic [15:0] pat [6] = '{16'hFFFF, 16'h1000, 16'h0100, 16'h0010, 16'h0001, 16'h0000};
      foreach (pat[i]) begin
         ffsr_host_model_inst.wr(8'h14, pat[i]);
         check({12'h000, drive}, {12'h000, pat[i][12], pat[i][8], pat[i][4], pat[i][0]});
         ffsr_host_model_inst.rd(8'h94, v); check(v, pat[i] & 16'h1111);
      end
      ffsr_host_model_inst.wr(8'h94, 16'hFFFF);
      ffsr_host_model_inst.rd(8'h94, v); check(v, 16'h0000);
      ffsr_host_model_inst.wr(8'h8C, 16'hFFFF);
      ffsr_host_model_inst.rd(8'h8C, v); check(v, 16'h0000);
   endtask
   // Every flag: set, refused clear, zero write, clear
   task automatic t_faults;
      for (int n = 0; n < 12; n++) begin
         fault_i = ffsr_fault_t'(12'h001 << n);
         ffsr_host_model_inst.wr(8'h0C, 16'h0FFF);
         ffsr_host_model_inst.rd(8'h8C, v); check(v, 16'h0001 << n);
         check({15'h0, diag_n}, 16'h0000);
         fault_i = '0;
         ffsr_host_model_inst.wr(8'h0C, ~(16'h0001 << n) & 16'h0FFF);
         ffsr_host_model_inst.rd(8'h8C, v); check(v, 16'h0001 << n);
         ffsr_host_model_inst.wr(8'h0C, 16'h0001 << n);
         ffsr_host_model_inst.rd(8'h8C, v); check(v, 16'h0000);
         check({15'h0, diag_n}, 16'h0001);
      end
   endtask
   // Check-answer flags at their bits, unmapped read
   task automatic t_answer;
      for (int a = 0; a < 8; a++) begin
         answer_i = ffsr_answer_t'(a[2:0]);
         ffsr_host_model_inst.rd(8'h88, v); check(v & 16'h0007, {13'h0, a[2:0]});
      end
      ffsr_host_model_inst.rd(8'h0C, v); check(v, 16'h0000);
   endtask
   // Named detector fields at their status bits
   task automatic t_map;
      fault_i = '{gate_ovp_u_high: 1'b1, drain_fault_v_low: 1'b1, drain_fault_w_low: 1'b1,
                  default: 1'b0};
      ffsr_host_model_inst.rd(8'h8C, v); check(v & 16'h0F00, 16'h0800);
      check(v & 16'h00F0, 16'h0010);
      check(v & 16'h000F, 16'h0001);
      fault_i = '0;
      ffsr_host_model_inst.wr(8'h0C, 16'h0FFF);
      ffsr_host_model_inst.rd(8'h8C, v); check(v, 16'h0000);
   endtask
   // Reset in mid-run restores every default
   task automatic t_rerun;
      ffsr_host_model_inst.wr(8'h14, 16'h0111);
      check({12'h000, drive}, 16'h0007);
      fault_i = '{gate_ovp_v_low: 1'b1, default: 1'b0};
      @(posedge ref_clk_i);
      #1 fault_i = '0;
      check({15'h0, diag_n}, 16'h0000);
      reset_i = 1'b1;
      repeat (2) @(posedge ref_clk_i);
      #1 reset_i = 1'b0;
      check({12'h000, drive}, 16'h0008);
      check({15'h0, diag_n}, 16'h0001);
      ffsr_host_model_inst.rd(8'h8C, v); check(v, 16'h0000);
      ffsr_host_model_inst.rd(8'h94, v); check(v, 16'h1000);
   endtask
   // =========================================================
   // Sequence and watchdog
   // =========================================================
   initial begin
      repeat (2) @(posedge ref_clk_i);
      #1 reset_i = 1'b0;
      t_reset();
      t_ctrl();
      t_faults();
      t_answer();
      t_map();
      t_rerun();
      give_verdict();
   end
   initial begin
      #200000;
      err_count++;
      give_verdict();
   end
endmodule // ffsr_regs_tb
